// ### coef_scale.sv
`timescale 1ns/1ps
module coef_scale (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Filter settings
  filter_cfg_if.dst cfg,
  // Coefficient
  input wire logic [fir_eq_pkg::COEF_W-1:0] coefRaw,
  input wire logic isCenter,
  output logic [fir_eq_pkg::SCALED_W-1:0] coefScaled
);

  logic [fir_eq_pkg::SCALED_W-1:0] scaledReg;
  logic [fir_eq_pkg::SCALED_W-1:0] scaledNext;
  logic [fir_eq_pkg::SCALED_W-1:0] signExt;

  always_comb begin
    // Two's complement, sign carried into the wider word
    signExt = {{(fir_eq_pkg::SCALED_W - fir_eq_pkg::COEF_W){coefRaw[fir_eq_pkg::COEF_W-1]}},
      coefRaw}; // [R16]
    if (cfg.enable && !isCenter) begin
      // Result in units of two to the minus sixteenth
      scaledNext = signExt << cfg.weight; // [R11]
    end else begin
      scaledNext = signExt; // [R17]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      scaledReg <= '0;
    end else begin
      scaledReg <= scaledNext;
    end
  end

  assign coefScaled = scaledReg;

endmodule

// ### filter_cfg_if.sv
`timescale 1ns/1ps
interface filter_cfg_if;
  logic enable;
  logic share;
  logic merge;
  logic [fir_eq_pkg::SCW_W-1:0] weight;
  modport src (output enable, output share, output merge, output weight);
  modport dst (input enable, input share, input merge, input weight);
endinterface

// ### fir_eq_assertions.sv
`timescale 1ns/1ps
module fir_eq_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [fir_eq_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Fuse
  input wire logic fuseValid,
  input wire logic [29:0] fuseTrims,
  input wire logic fuseLoaded,
  input wire logic [fir_eq_pkg::TRIM_W-1:0] trimA0Single,
  // Filter
  input wire logic [fir_eq_pkg::COEF_W-1:0] coefTapA,
  input wire logic [fir_eq_pkg::COEF_W-1:0] coefTapB,
  input wire logic coefIsCenter,
  input wire logic [fir_eq_pkg::SAMPLE_W-1:0] sampleInA,
  input wire logic [fir_eq_pkg::SAMPLE_W-1:0] filteredInA,
  input wire logic [fir_eq_pkg::SAMPLE_W-1:0] sampleOutA,
  input wire logic filterEnable,
  input wire logic coefShareBit,
  input wire logic filterMergeBit,
  input wire logic [fir_eq_pkg::SCALED_W-1:0] coefScaledA,
  input wire logic [fir_eq_pkg::SCALED_W-1:0] coefScaledB
);
  logic [17:0] extA;
  logic [17:0] extB;
  logic [4:0] fuseA0;
  assign extA = {{6{coefTapA[11]}}, coefTapA};
  assign extB = {{6{coefTapB[11]}}, coefTapB};
  assign fuseA0 = fuseTrims[14:10];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  bypass_pass_a: assert property (!filterEnable |=> sampleOutA == $past(sampleInA))
    else $error("bypass sample altered");
  filter_pass_a: assert property (filterEnable |=> sampleOutA == $past(filteredInA))
    else $error("filtered sample not selected");
  raw_coef_a: assert property (!filterEnable || coefIsCenter |=> coefScaledA == $past(extA))
    else $error("unshifted coefficient wrong");
  share_coef_a: assert property ((coefShareBit || filterMergeBit) &&
    (!filterEnable || coefIsCenter) |=> coefScaledB == $past(extA)) else $error("B not shared");
  own_coef_a: assert property (!coefShareBit && !filterMergeBit && !filterEnable
    |=> coefScaledB == $past(extB)) else $error("B not own set");
  fuse_copy_a: assert property ($rose(fuseLoaded) |->
    $past(fuseValid, 2) && trimA0Single == $past(fuseA0)) else $error("fuse copy wrong");
  loaded_hold_a: assert property (fuseLoaded |=> fuseLoaded) else $error("fuse flag fell");
  cover property ($rose(fuseLoaded));
  cover property (filterEnable && coefShareBit);
  cover property (wb_ack_o && filterMergeBit);
endmodule

bind fir_equalizer_gain_trim fir_eq_assertions u_fir_eq_assertions (
  .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fuseValid(fuseValid), .fuseTrims(fuseTrims),
  .fuseLoaded(fuseLoaded), .trimA0Single(trimA0Single), .coefTapA(coefTapA),
  .coefTapB(coefTapB), .coefIsCenter(coefIsCenter), .sampleInA(sampleInA),
  .filteredInA(filteredInA), .sampleOutA(sampleOutA), .filterEnable(filterEnable),
  .coefShareBit(coefShareBit), .filterMergeBit(filterMergeBit),
  .coefScaledA(coefScaledA), .coefScaledB(coefScaledB));

// ### fir_eq_pkg.sv
package fir_eq_pkg;

  // Wishbone geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;
  localparam int IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_GAIN_B0_DUAL = 12'h352;
  localparam logic [11:0] IDX_GAIN_B1_DUAL = 12'h353;
  localparam logic [11:0] IDX_GAIN_A0_SINGLE = 12'h354;
  localparam logic [11:0] IDX_GAIN_A1_SINGLE = 12'h355;
  localparam logic [11:0] IDX_GAIN_B0_SINGLE = 12'h356;
  localparam logic [11:0] IDX_GAIN_B1_SINGLE = 12'h357;
  localparam logic [11:0] IDX_FILTER_CFG = 12'h400;
  localparam logic [11:0] IDX_STATUS = 12'h401;
  localparam int TRIM_COUNT = 6;

  // Register widths and reset values
  localparam int REG_W = 8;
  localparam int TRIM_W = 5;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Filter configuration fields
  localparam int SHARE_BIT = 6;
  localparam int MERGE_BIT = 5;
  localparam int SCW_LSB = 2;
  localparam int SCW_W = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_BYPASS = 2'h0;
  localparam logic [1:0] MODE_ENABLE = 2'h2;
  localparam logic [2:0] SCW_MAX = 3'h6;

  // Status fields
  localparam int STAT_LOADED = 0;
  localparam int STAT_LINK = 1;
  localparam int STAT_MODE_RSVD = 2;
  localparam int STAT_SCW_RANGE = 3;

  // Data path widths
  localparam int COEF_W = 12;
  localparam int SCALED_W = 18;
  localparam int SAMPLE_W = 8;

  typedef enum logic [1:0] {
    ST_WAIT_FUSE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } fuse_state_type;

endpackage

// ### fir_equalizer_gain_trim.sv
// Behaviour
// R1: Core B bank 0 uses its own 5-bit dual-mode trim in bits 4:0 while in dual channel mode.
// R2: Core B bank 1 uses a separate 5-bit dual-mode trim in bits 4:0 in dual channel mode.
// R3: Core A bank 0 uses a dedicated 5-bit single-mode trim in bits 4:0 in single channel mode.
// R4: Core A bank 1 uses a dedicated 5-bit single-mode trim in bits 4:0 in single channel mode.
// R5: Core B bank 0 uses a dedicated 5-bit single-mode trim in bits 4:0 in single channel mode.
// R6: Core B bank 1 uses a dedicated 5-bit single-mode trim; bits 7:5 of trims are reserved.
// R7: After power-up every trim field is loaded from fuse storage instead of staying zero.
// R8: Share bit 6 set makes the B filter use the A coefficients, else its own set; the code also gives B the A set while merge bit 5 is set.
// R9: Merge bit 5 set joins both filters into one filter over one interleaved stream.
// R10: Software sets the merge bit whenever the converter runs single channel.
// R11: Side coefficients have an LSB weight of two to the weight field (bits 4:2) minus 16.
// R12: Software writes only 0 to 6 into the weight field; 0 gives two to the minus 16.
// R13: Mode field bits 1:0: 0 bypasses the filter, 2 enables it, 1 and 3 are reserved.
// R14: Software enabling the filter also writes the intended coefficients.
// R15: Software changes filter settings only while the link enable is 0.
// R16: Each coefficient is a 12-bit signed two's complement value; tap A0 comes first.
// R17: In bypass the samples pass unchanged and no coefficient scaling applies.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module fir_equalizer_gain_trim (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fir_eq_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [fir_eq_pkg::DATA_W-1:0] wb_dat_i,
  output logic [fir_eq_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Fuse storage
  input wire logic fuseValid,
  input wire logic [29:0] fuseTrims,
  // Device mode
  input wire logic singleChannel,
  input wire logic linkEnable,
  // Coefficients from the tap store
  input wire logic [fir_eq_pkg::COEF_W-1:0] coefTapA,
  input wire logic [fir_eq_pkg::COEF_W-1:0] coefTapB,
  input wire logic coefIsCenter,
  // Samples
  input wire logic [fir_eq_pkg::SAMPLE_W-1:0] sampleInA,
  input wire logic [fir_eq_pkg::SAMPLE_W-1:0] sampleInB,
  input wire logic [fir_eq_pkg::SAMPLE_W-1:0] filteredInA,
  input wire logic [fir_eq_pkg::SAMPLE_W-1:0] filteredInB,
  output logic [fir_eq_pkg::SAMPLE_W-1:0] sampleOutA,
  output logic [fir_eq_pkg::SAMPLE_W-1:0] sampleOutB,
  // Filter settings
  output logic filterEnable,
  output logic coefShareBit,
  output logic filterMergeBit,
  output logic [fir_eq_pkg::SCALED_W-1:0] coefScaledA,
  output logic [fir_eq_pkg::SCALED_W-1:0] coefScaledB,
  // Applied gain trims
  output logic [fir_eq_pkg::TRIM_W-1:0] trimB0,
  output logic [fir_eq_pkg::TRIM_W-1:0] trimB1,
  output logic [fir_eq_pkg::TRIM_W-1:0] trimA0Single,
  output logic [fir_eq_pkg::TRIM_W-1:0] trimA1Single,
  output logic fuseLoaded
);

  // Trim register slots, in index order from the first trim offset
  localparam int SLOT_B0_DUAL = 0;
  localparam int SLOT_B1_DUAL = 1;
  localparam int SLOT_A0_SINGLE = 2;
  localparam int SLOT_A1_SINGLE = 3;
  localparam int SLOT_B0_SINGLE = 4;
  localparam int SLOT_B1_SINGLE = 5;

  // Bus state
  logic ackReg;
  logic ackNext;
  logic [fir_eq_pkg::DATA_W-1:0] datReg;
  logic [fir_eq_pkg::DATA_W-1:0] datNext;
  logic [fir_eq_pkg::IDX_W-1:0] regIndex;
  logic alignedAddr;
  logic busWrite;
  logic [fir_eq_pkg::REG_W-1:0] readValue;

  // Configuration state
  fir_eq_pkg::fuse_state_type stateReg;
  fir_eq_pkg::fuse_state_type stateNext;
  logic [fir_eq_pkg::REG_W-1:0] trimReg [fir_eq_pkg::TRIM_COUNT];
  logic [fir_eq_pkg::REG_W-1:0] trimNext [fir_eq_pkg::TRIM_COUNT];
  logic [fir_eq_pkg::REG_W-1:0] cfgReg;
  logic [fir_eq_pkg::REG_W-1:0] cfgNext;
  logic [fir_eq_pkg::REG_W-1:0] statusValue;
  logic enableReg;
  logic enableNext;
  logic loadedReg;
  logic loadedNext;

  // Sample path state
  logic [fir_eq_pkg::SAMPLE_W-1:0] outAReg;
  logic [fir_eq_pkg::SAMPLE_W-1:0] outANext;
  logic [fir_eq_pkg::SAMPLE_W-1:0] outBReg;
  logic [fir_eq_pkg::SAMPLE_W-1:0] outBNext;

  // Decoded settings
  logic [fir_eq_pkg::MODE_W-1:0] modeField;
  logic modeEnabled;
  logic modeReserved;
  logic [fir_eq_pkg::COEF_W-1:0] coefSourceB;

  filter_cfg_if cfgBus ();

  // Register decode
  assign regIndex = wb_adr_i[fir_eq_pkg::ADDR_W-1:fir_eq_pkg::IDX_LSB];
  assign alignedAddr = (wb_adr_i[fir_eq_pkg::IDX_LSB-1:0] == 2'h0);
  // Writes land on the edge where the master sees ack
  assign busWrite = wb_cyc_i && wb_stb_i && ackReg && wb_we_i && wb_sel_i[0] && alignedAddr;

  assign modeField = cfgReg[fir_eq_pkg::MODE_LSB +: fir_eq_pkg::MODE_W];
  // Reserved codes are treated as bypass
  assign modeEnabled = (modeField == fir_eq_pkg::MODE_ENABLE); // [R13]
  assign modeReserved = (modeField != fir_eq_pkg::MODE_ENABLE) &&
    (modeField != fir_eq_pkg::MODE_BYPASS); // [R13]

  always_comb begin
    statusValue = '0;
    statusValue[fir_eq_pkg::STAT_LOADED] = (stateReg == fir_eq_pkg::ST_RUN);
    statusValue[fir_eq_pkg::STAT_LINK] = linkEnable;
    statusValue[fir_eq_pkg::STAT_MODE_RSVD] = modeReserved;
    // Flags a weight beyond the legal range
    statusValue[fir_eq_pkg::STAT_SCW_RANGE] =
      (cfgReg[fir_eq_pkg::SCW_LSB +: fir_eq_pkg::SCW_W] > fir_eq_pkg::SCW_MAX); // [R12]
  end

  always_comb begin
    readValue = '0;
    if (alignedAddr) begin
      case (regIndex)
        fir_eq_pkg::IDX_GAIN_B0_DUAL: readValue = trimReg[SLOT_B0_DUAL];
        fir_eq_pkg::IDX_GAIN_B1_DUAL: readValue = trimReg[SLOT_B1_DUAL];
        fir_eq_pkg::IDX_GAIN_A0_SINGLE: readValue = trimReg[SLOT_A0_SINGLE];
        fir_eq_pkg::IDX_GAIN_A1_SINGLE: readValue = trimReg[SLOT_A1_SINGLE];
        fir_eq_pkg::IDX_GAIN_B0_SINGLE: readValue = trimReg[SLOT_B0_SINGLE];
        fir_eq_pkg::IDX_GAIN_B1_SINGLE: readValue = trimReg[SLOT_B1_SINGLE];
        fir_eq_pkg::IDX_FILTER_CFG: readValue = cfgReg;
        fir_eq_pkg::IDX_STATUS: readValue = statusValue;
        default: readValue = '0;
      endcase
    end
  end

  // Every access is answered; unmapped ones read zero and drop writes
  always_comb begin
    ackNext = wb_cyc_i && wb_stb_i && !ackReg;
    datNext = datReg;
    if (ackNext) begin
      datNext = {{(fir_eq_pkg::DATA_W - fir_eq_pkg::REG_W){1'b0}}, readValue};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ackReg <= 1'b0;
      datReg <= '0;
    end else begin
      ackReg <= ackNext;
      datReg <= datNext;
    end
  end

  // Fuse load sequence
  always_comb begin
    case (stateReg)
      fir_eq_pkg::ST_WAIT_FUSE: begin
        stateNext = fuseValid ? fir_eq_pkg::ST_LOAD : fir_eq_pkg::ST_WAIT_FUSE;
      end
      fir_eq_pkg::ST_LOAD: begin
        stateNext = fir_eq_pkg::ST_RUN;
      end
      fir_eq_pkg::ST_RUN: begin
        stateNext = fir_eq_pkg::ST_RUN;
      end
      default: begin
        stateNext = fir_eq_pkg::ST_WAIT_FUSE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stateReg <= fir_eq_pkg::ST_WAIT_FUSE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Done flag taken from the next state, so it rises with the run state itself
  always_comb begin
    loadedNext = (stateNext == fir_eq_pkg::ST_RUN); // [R7]
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      loadedReg <= 1'b0;
    end else begin
      loadedReg <= loadedNext;
    end
  end

  // Trim registers; the fuse copy overrides a write in its one load cycle
  always_comb begin
    for (int i = 0; i < fir_eq_pkg::TRIM_COUNT; i++) begin
      trimNext[i] = trimReg[i];
      if (busWrite && (regIndex == fir_eq_pkg::IDX_GAIN_B0_DUAL + 12'(i))) begin
        trimNext[i] = wb_dat_i[fir_eq_pkg::REG_W-1:0];
      end
      if (stateReg == fir_eq_pkg::ST_LOAD) begin
        // Reserved upper bits start at zero
        trimNext[i] = {3'h0, fuseTrims[i*fir_eq_pkg::TRIM_W +: fir_eq_pkg::TRIM_W]}; // [R7]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < fir_eq_pkg::TRIM_COUNT; i++) begin
        trimReg[i] <= fir_eq_pkg::TRIM_RESET;
      end
    end else begin
      for (int i = 0; i < fir_eq_pkg::TRIM_COUNT; i++) begin
        trimReg[i] <= trimNext[i];
      end
    end
  end

  // Filter configuration; the link enable is not checked, software owns that
  always_comb begin
    cfgNext = cfgReg;
    if (busWrite && (regIndex == fir_eq_pkg::IDX_FILTER_CFG)) begin
      cfgNext = wb_dat_i[fir_eq_pkg::REG_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfgReg <= fir_eq_pkg::CFG_RESET;
    end else begin
      cfgReg <= cfgNext;
    end
  end

  // Registered copy of the mode decode, in step with the live mode field
  always_comb begin
    enableNext = (cfgNext[fir_eq_pkg::MODE_LSB +: fir_eq_pkg::MODE_W] ==
      fir_eq_pkg::MODE_ENABLE); // [R13]
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      enableReg <= 1'b0;
    end else begin
      enableReg <= enableNext;
    end
  end

  assign cfgBus.enable = modeEnabled; // [R13]
  assign cfgBus.share = cfgReg[fir_eq_pkg::SHARE_BIT]; // [R8]
  assign cfgBus.merge = cfgReg[fir_eq_pkg::MERGE_BIT]; // [R9]
  assign cfgBus.weight = cfgReg[fir_eq_pkg::SCW_LSB +: fir_eq_pkg::SCW_W]; // [R11]

  // Merged filter runs on one tap set starting at A0, so B follows A
  assign coefSourceB = (cfgBus.share || cfgBus.merge) ? coefTapA : coefTapB; // [R8] [R9]

  coef_scale scaleA (
    .clk_sys (clk_sys),
    .rst_b (rst_b),
    .cfg (cfgBus.dst),
    .coefRaw (coefTapA),
    .isCenter (coefIsCenter),
    .coefScaled (coefScaledA)
  );

  coef_scale scaleB (
    .clk_sys (clk_sys),
    .rst_b (rst_b),
    .cfg (cfgBus.dst),
    .coefRaw (coefSourceB),
    .isCenter (coefIsCenter),
    .coefScaled (coefScaledB)
  );

  // Sample path
  always_comb begin
    if (modeEnabled) begin
      outANext = filteredInA;
      outBNext = filteredInB;
    end else begin
      outANext = sampleInA; // [R17]
      outBNext = sampleInB; // [R17]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      outAReg <= '0;
      outBReg <= '0;
    end else begin
      outAReg <= outANext;
      outBReg <= outBNext;
    end
  end

  // Core B trims follow the channel mode
  trim_select selB0 (
    .clk_sys (clk_sys),
    .rst_b (rst_b),
    .dualTrim (trimReg[SLOT_B0_DUAL][fir_eq_pkg::TRIM_W-1:0]), // [R1]
    .singleTrim (trimReg[SLOT_B0_SINGLE][fir_eq_pkg::TRIM_W-1:0]), // [R5]
    .singleChannel (singleChannel),
    .trimOut (trimB0)
  );

  trim_select selB1 (
    .clk_sys (clk_sys),
    .rst_b (rst_b),
    .dualTrim (trimReg[SLOT_B1_DUAL][fir_eq_pkg::TRIM_W-1:0]), // [R2]
    .singleTrim (trimReg[SLOT_B1_SINGLE][fir_eq_pkg::TRIM_W-1:0]), // [R6]
    .singleChannel (singleChannel),
    .trimOut (trimB1)
  );

  // Core A single-mode trims, driven out unchanged in both dual and single channel mode
  assign trimA0Single = trimReg[SLOT_A0_SINGLE][fir_eq_pkg::TRIM_W-1:0]; // [R3]
  assign trimA1Single = trimReg[SLOT_A1_SINGLE][fir_eq_pkg::TRIM_W-1:0]; // [R4]

  assign wb_ack_o = ackReg;
  assign wb_dat_o = datReg;
  assign sampleOutA = outAReg;
  assign sampleOutB = outBReg;
  assign filterEnable = enableReg;
  assign coefShareBit = cfgReg[fir_eq_pkg::SHARE_BIT];
  assign filterMergeBit = cfgReg[fir_eq_pkg::MERGE_BIT];
  assign fuseLoaded = loadedReg;

endmodule

// ### tb_fir_equalizer_gain_trim.sv
`timescale 1ns/1ps
module tb_fir_equalizer_gain_trim;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [13:0] wb_adr_i = 14'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, r, r2;
  logic [31:0] seed = 32'h00009112;
  logic fuseValid = 1'b0, singleChannel = 1'b0, linkEnable = 1'b0, coefIsCenter = 1'b0;
  logic [29:0] fuseTrims = 30'h00000000;
  logic [11:0] coefTapA = 12'h000, coefTapB = 12'h000;
  logic [7:0] sampleInA = 8'h00, sampleInB = 8'h00, filteredInA = 8'h00, filteredInB = 8'h00;
  logic [7:0] sampleOutA, sampleOutB, rd, cfg;
  logic [7:0] trimVal [6];
  logic filterEnable, coefShareBit, filterMergeBit, fuseLoaded, en;
  logic [17:0] coefScaledA, coefScaledB;
  logic [4:0] trimB0, trimB1, trimA0Single, trimA1Single;
  logic [2:0] w;
  int fails = 0, cmp_count = 0;

  fir_equalizer_gain_trim u_fir_equalizer_gain_trim (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fuseValid(fuseValid), .fuseTrims(fuseTrims),
    .singleChannel(singleChannel), .linkEnable(linkEnable), .coefTapA(coefTapA),
    .coefTapB(coefTapB), .coefIsCenter(coefIsCenter), .sampleInA(sampleInA),
    .sampleInB(sampleInB), .filteredInA(filteredInA), .filteredInB(filteredInB),
    .sampleOutA(sampleOutA), .sampleOutB(sampleOutB), .filterEnable(filterEnable),
    .coefShareBit(coefShareBit), .filterMergeBit(filterMergeBit), .coefScaledA(coefScaledA),
    .coefScaledB(coefScaledB), .trimB0(trimB0), .trimB1(trimB1),
    .trimA0Single(trimA0Single), .trimA1Single(trimA1Single), .fuseLoaded(fuseLoaded));

  always #2.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [17:0] ext(input logic [11:0] c, input logic [2:0] sh);
    return {{6{c[11]}}, c} << sh;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Read data taken while ack stands, request dropped on the edge that samples it
  task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d,
                    input logic s0, output logic [7:0] q);
    int n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= {3'b000, s0};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check(wb_ack_o, 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    r = nxt();
    fuseTrims <= r[29:0];
    // Fuse held back so the zero reset values are visible first
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, fir_eq_pkg::IDX_GAIN_B0_DUAL + 12'(i), 8'h00, 1'b1, rd);
      check(rd, 8'h00);
    end
    wb(1'b0, fir_eq_pkg::IDX_FILTER_CFG, 8'h00, 1'b1, rd);
    check(rd, 8'h00);
    check(fuseLoaded, 1'b0);
    @(posedge clk_sys);
    fuseValid <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check(fuseLoaded, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, fir_eq_pkg::IDX_GAIN_B0_DUAL + 12'(i), 8'h00, 1'b1, rd);
      check(rd, {3'b000, r[5 * i +: 5]});
    end
    wb(1'b0, fir_eq_pkg::IDX_STATUS, 8'h00, 1'b1, rd);
    check(rd[1:0], 2'b01);
    for (int i = 0; i < 6; i++) begin
      r = nxt();
      trimVal[i] = r[7:0];
      wb(1'b1, fir_eq_pkg::IDX_GAIN_B0_DUAL + 12'(i), r[7:0], 1'b1, rd);
    end
    wb(1'b1, fir_eq_pkg::IDX_GAIN_B0_DUAL, ~trimVal[0], 1'b0, rd);
    wb(1'b1, 12'h123, 8'hFF, 1'b1, rd);
    wb(1'b0, 12'h123, 8'h00, 1'b1, rd);
    check(rd, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, fir_eq_pkg::IDX_GAIN_B0_DUAL + 12'(i), 8'h00, 1'b1, rd);
      check(rd, trimVal[i]);
    end
    // Ends in dual mode, so random merge settings stay legal below
    for (int sc = 1; sc >= 0; sc--) begin
      wb(1'b1, fir_eq_pkg::IDX_FILTER_CFG, {2'b00, sc[0], 5'h00}, 1'b1, rd);
      @(posedge clk_sys);
      singleChannel <= sc[0];
      repeat (3) @(posedge clk_sys);
      #1 check(trimB0, sc ? trimVal[4][4:0] : trimVal[0][4:0]);
      check(trimB1, sc ? trimVal[5][4:0] : trimVal[1][4:0]);
      check(trimA0Single, trimVal[2][4:0]);
      check(trimA1Single, trimVal[3][4:0]);
    end
    // Link stays disabled for every write below weight kept to 0..6
    for (int k = 0; k < 28; k++) begin
      r = nxt();
      w = 3'(k % 7);
      cfg = {1'b0, r[6], r[5], w, 2'(k % 4)};
      en = (k % 4 == 2);
      wb(1'b1, fir_eq_pkg::IDX_FILTER_CFG, cfg, 1'b1, rd);
      wb(1'b0, fir_eq_pkg::IDX_FILTER_CFG, 8'h00, 1'b1, rd);
      check(rd, cfg);
      wb(1'b0, fir_eq_pkg::IDX_STATUS, 8'h00, 1'b1, rd);
      check(rd[3:0], {1'b0, k[0], 2'b01});
      r2 = nxt();
      @(posedge clk_sys);
      {filteredInB, sampleInB, filteredInA, sampleInA} <= r;
      {coefIsCenter, coefTapB, coefTapA} <= r2[24:0];
      @(posedge clk_sys);
      #1 check(filterEnable, en);
      check(coefShareBit, r[6]);
      check(filterMergeBit, r[5]);
      check(sampleOutA, en ? r[15:8] : r[7:0]);
      check(sampleOutB, en ? r[31:24] : r[23:16]);
      check(coefScaledA, ext(r2[11:0], en && !r2[24] ? w : 3'h0));
      check(coefScaledB, ext(r[6] | r[5] ? r2[11:0] : r2[23:12],
                             en && !r2[24] ? w : 3'h0));
    end
    // Last setting is mode 3 with weight 6; link now reported as enabled
    @(posedge clk_sys);
    linkEnable <= 1'b1;
    wb(1'b0, fir_eq_pkg::IDX_STATUS, 8'h00, 1'b1, rd);
    check(rd[3:0], 4'h7);
    conclude();
  end
endmodule

// ### trim_select.sv
`timescale 1ns/1ps
module trim_select (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Trim sources
  input wire logic [fir_eq_pkg::TRIM_W-1:0] dualTrim,
  input wire logic [fir_eq_pkg::TRIM_W-1:0] singleTrim,
  input wire logic singleChannel,
  // Applied trim
  output logic [fir_eq_pkg::TRIM_W-1:0] trimOut
);

  logic [fir_eq_pkg::TRIM_W-1:0] trimReg;
  logic [fir_eq_pkg::TRIM_W-1:0] trimNext;

  always_comb begin
    trimNext = singleChannel ? singleTrim : dualTrim;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      trimReg <= '0;
    end else begin
      trimReg <= trimNext;
    end
  end

  assign trimOut = trimReg;

endmodule
